// ---- hdl/ipl_map.svh ----
// address indices, field positions, write masks and codes of the priority level registers
`ifndef IPL_MAP_SVH
`define IPL_MAP_SVH

`define IPL_ADDR_W        12
`define IPL_IDX_W         10
`define IPL_REG_W         16
`define IPL_NSRC          24
`define IPL_FIELD_W       2

`define IPL_IDX_PRIO2     10'h002
`define IPL_IDX_PRIO3     10'h003
`define IPL_IDX_PRIO4     10'h004
`define IPL_IDX_PRIO5     10'h005

`define IPL_RESET_VAL     16'h0000
`define IPL_WMASK_PRIO2   16'h03CF
`define IPL_WMASK_PRIO3   16'hFFFC
`define IPL_WMASK_PRIO4   16'hFC3F
`define IPL_WMASK_PRIO5   16'hFF3F

`define IPL_CODE_OFF      2'h0
`define IPL_CODE_L0       2'h1
`define IPL_CODE_L1       2'h2
`define IPL_CODE_L2       2'h3

`define IPL_RESP_OKAY     2'h0
`define IPL_RESP_SLVERR   2'h2

`define IPL_LSB_PLL_UNLOCK      8
`define IPL_LSB_LOW_VOLTAGE     6
`define IPL_LSB_EXT_LINE_B      2
`define IPL_LSB_EXT_LINE_A      0
`define IPL_LSB_PORT_D          14
`define IPL_LSB_PORT_E          12
`define IPL_LSB_PORT_F          10
`define IPL_LSB_CAN_MSGBUF      8
`define IPL_LSB_CAN_WAKEUP      6
`define IPL_LSB_CAN_ERROR       4
`define IPL_LSB_CAN_BUSOFF      2
`define IPL_LSB_SERIAL0_RXFULL  14
`define IPL_LSB_SERIAL1_TXEMPTY 12
`define IPL_LSB_SERIAL1_RXFULL  10
`define IPL_LSB_PORT_A          4
`define IPL_LSB_PORT_B          2
`define IPL_LSB_PORT_C          0
`define IPL_LSB_DECODER1_INDEX  14
`define IPL_LSB_DECODER1_HOME   12
`define IPL_LSB_UART1_RXFULL    10
`define IPL_LSB_UART1_RXERROR   8
`define IPL_LSB_UART1_TXIDLE    4
`define IPL_LSB_UART1_TXEMPTY   2
`define IPL_LSB_SERIAL0_TXEMPTY 0

`endif

// ---- hdl/ipl_pkg.sv ----
// types shared by the priority level register block
`include "ipl_map.svh"
package ipl_pkg;

    // per-level request vectors towards the core, one bit per source
    typedef struct packed {
        logic [`IPL_NSRC-1:0] lvl2;
        logic [`IPL_NSRC-1:0] lvl1;
        logic [`IPL_NSRC-1:0] lvl0;
    } ipl_lvl_t;

    // summary of the highest level request and its lowest numbered source
    typedef struct packed {
        logic       any;
        logic [1:0] level;
        logic [4:0] src;
    } ipl_top_t;

    // one-hot write channel states
    typedef enum logic [4:0] {
        IPL_W_IDLE   = 5'h01,
        IPL_W_HAVE_A = 5'h02,
        IPL_W_HAVE_D = 5'h04,
        IPL_W_WRITE  = 5'h08,
        IPL_W_RESP   = 5'h10
    } ipl_wstate_t;

    // true for a word index that holds a priority register
    function automatic logic is_mapped(input logic [`IPL_IDX_W-1:0] idx);
        is_mapped = (idx == `IPL_IDX_PRIO2) || (idx == `IPL_IDX_PRIO3) ||
                    (idx == `IPL_IDX_PRIO4) || (idx == `IPL_IDX_PRIO5);
    endfunction : is_mapped

endpackage : ipl_pkg

// ---- hdl/ipl_level_decode.sv ----
// per-source field decode into registered level request vectors
`timescale 1ns/100ps
`include "ipl_map.svh"
module ipl_level_decode (
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    input  wire logic [`IPL_NSRC*`IPL_FIELD_W-1:0]    fields,
    input  wire logic [`IPL_NSRC-1:0]                 src_req,
    output ipl_pkg::ipl_lvl_t                         lvl
);

    // a field matches one level code only, so code 00 matches none
    function automatic logic code_hit(input logic [1:0] code, input logic [1:0] want);
        code_hit = (code == want);
    endfunction : code_hit

    // registered so the core sees glitch-free level lines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl <= '0;
        end else begin
            for (int i = 0; i < `IPL_NSRC; i++) begin
                lvl.lvl0[i] <= src_req[i] && code_hit(fields[2*i +: 2], `IPL_CODE_L0);
                lvl.lvl1[i] <= src_req[i] && code_hit(fields[2*i +: 2], `IPL_CODE_L1);
                lvl.lvl2[i] <= src_req[i] && code_hit(fields[2*i +: 2], `IPL_CODE_L2);
            end
        end
    end

endmodule : ipl_level_decode

// ---- hdl/ipl_level_top.sv ----
// picks the highest requested level and its lowest numbered source
`timescale 1ns/100ps
`include "ipl_map.svh"
module ipl_level_top (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  ipl_pkg::ipl_lvl_t         lvl,
    output ipl_pkg::ipl_top_t         top
);

    ipl_pkg::ipl_top_t top_d;

    // level 2 beats 1 beats 0; ties go to the lowest source number
    always_comb begin
        logic [`IPL_NSRC-1:0] vec;
        vec   = '0;
        top_d = '0;
        if (|lvl.lvl2) begin
            vec         = lvl.lvl2;
            top_d.level = 2'h2;
        end else if (|lvl.lvl1) begin
            vec         = lvl.lvl1;
            top_d.level = 2'h1;
        end else begin
            vec         = lvl.lvl0;
            top_d.level = 2'h0;
        end
        top_d.any = |vec;
        for (int i = `IPL_NSRC - 1; i >= 0; i--) begin
            if (vec[i]) begin
                top_d.src = 5'(i);
            end
        end
    end

    // summary lags the level vectors by one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            top <= '0;
        end else begin
            top <= top_d;
        end
    end

endmodule : ipl_level_top

// ---- hdl/ipl_prio_regs.sv ----
// priority level registers with an AXI4-Lite slave and level request outputs
`timescale 1ns/100ps
`include "ipl_map.svh"
// Notes on behaviour
// - field code 00 off, 01 level 0, 10 level 1, 11 level 2; no level 3
// - every priority field resets to the disabled code
// - reserved bits read zero and ignore writes
// - second register: pll unlock at 9-8, low voltage at 7-6, 5-4 reserved
// - second register: external line b at 3-2, line a at 1-0
// - third register: ports d e f, then can sources; 1-0 reserved
// - fourth register: serial sources at 15-10, 9-6 reserved, ports a b c below
// - fifth register: decoder, uart sources, reserved 7-6, serial0 txempty; resets zero
module ipl_prio_regs (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [`IPL_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`IPL_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [`IPL_NSRC-1:0]    src_req,
    output ipl_pkg::ipl_lvl_t            core_lvl,
    output ipl_pkg::ipl_top_t            core_top
);

    ipl_pkg::ipl_wstate_t        wstate_q;
    ipl_pkg::ipl_wstate_t        wstate_d;
    logic [`IPL_IDX_W-1:0]       widx_q;
    logic [15:0]                 wdata_q;
    logic [1:0]                  wstrb_q;
    logic [1:0]                  bresp_q;
    logic                        rvalid_q;
    logic [31:0]                 rdata_q;
    logic [1:0]                  rresp_q;
    logic [`IPL_REG_W-1:0]       prio2_q;
    logic [`IPL_REG_W-1:0]       prio3_q;
    logic [`IPL_REG_W-1:0]       prio4_q;
    logic [`IPL_REG_W-1:0]       prio5_q;
    logic                        aw_hs;
    logic                        w_hs;
    logic                        ar_hs;
    logic                        wr_fire;
    logic [`IPL_IDX_W-1:0]       ridx;
    logic [`IPL_NSRC*`IPL_FIELD_W-1:0] fields;

    logic [1:0] pll_unlock_level;
    logic [1:0] low_voltage_level;
    logic [1:0] ext_line_b_level;
    logic [1:0] ext_line_a_level;
    logic [1:0] port_d_level;
    logic [1:0] port_e_level;
    logic [1:0] port_f_level;
    logic [1:0] can_msgbuf_level;
    logic [1:0] can_wakeup_level;
    logic [1:0] can_error_level;
    logic [1:0] can_busoff_level;
    logic [1:0] serial0_rxfull_level;
    logic [1:0] serial1_txempty_level;
    logic [1:0] serial1_rxfull_level;
    logic [1:0] port_a_level;
    logic [1:0] port_b_level;
    logic [1:0] port_c_level;
    logic [1:0] decoder1_index_level;
    logic [1:0] decoder1_home_level;
    logic [1:0] uart1_rxfull_level;
    logic [1:0] uart1_rxerror_level;
    logic [1:0] uart1_txidle_level;
    logic [1:0] uart1_txempty_level;
    logic [1:0] serial0_txempty_level;

    // byte-lane merge, then the mask forces reserved positions back to zero
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] data,
                                          input logic [1:0]  strb,
                                          input logic [15:0] wmask);
        logic [15:0] m;
        m[7:0]  = strb[0] ? data[7:0]  : old[7:0];
        m[15:8] = strb[1] ? data[15:8] : old[15:8];
        merge   = m & wmask;
    endfunction : merge

    // word index from a byte address; the two low bits are ignored
    function automatic logic [`IPL_IDX_W-1:0] word_idx(input logic [`IPL_ADDR_W-1:0] a);
        word_idx = a[`IPL_ADDR_W-1:2];
    endfunction : word_idx

    // read view of one register; reserved bits are already zero in storage
    function automatic logic [15:0] read_word(input logic [`IPL_IDX_W-1:0] idx,
                                              input logic [15:0] r2,
                                              input logic [15:0] r3,
                                              input logic [15:0] r4,
                                              input logic [15:0] r5);
        case (idx)
            `IPL_IDX_PRIO2: read_word = r2 & `IPL_WMASK_PRIO2;
            `IPL_IDX_PRIO3: read_word = r3 & `IPL_WMASK_PRIO3;
            `IPL_IDX_PRIO4: read_word = r4 & `IPL_WMASK_PRIO4;
            `IPL_IDX_PRIO5: read_word = r5 & `IPL_WMASK_PRIO5;
            default:        read_word = `IPL_RESET_VAL;
        endcase
    endfunction : read_word

    // write channel handshakes; address and data may come in either order
    assign s_axi_awready = (wstate_q == ipl_pkg::IPL_W_IDLE) ||
                           (wstate_q == ipl_pkg::IPL_W_HAVE_D);
    assign s_axi_wready  = (wstate_q == ipl_pkg::IPL_W_IDLE) ||
                           (wstate_q == ipl_pkg::IPL_W_HAVE_A);
    assign s_axi_bvalid  = (wstate_q == ipl_pkg::IPL_W_RESP);
    assign s_axi_bresp   = bresp_q;
    assign aw_hs         = s_axi_awvalid && s_axi_awready;
    assign w_hs          = s_axi_wvalid && s_axi_wready;
    assign wr_fire       = (wstate_q == ipl_pkg::IPL_W_WRITE) &&
                           (bresp_q == `IPL_RESP_OKAY);

    // next write state
    always_comb begin
        wstate_d = wstate_q;
        case (wstate_q)
            ipl_pkg::IPL_W_IDLE: begin
                if (aw_hs && w_hs) begin
                    wstate_d = ipl_pkg::IPL_W_WRITE;
                end else if (aw_hs) begin
                    wstate_d = ipl_pkg::IPL_W_HAVE_A;
                end else if (w_hs) begin
                    wstate_d = ipl_pkg::IPL_W_HAVE_D;
                end
            end
            ipl_pkg::IPL_W_HAVE_A: begin
                if (w_hs) begin
                    wstate_d = ipl_pkg::IPL_W_WRITE;
                end
            end
            ipl_pkg::IPL_W_HAVE_D: begin
                if (aw_hs) begin
                    wstate_d = ipl_pkg::IPL_W_WRITE;
                end
            end
            ipl_pkg::IPL_W_WRITE: begin
                wstate_d = ipl_pkg::IPL_W_RESP;
            end
            ipl_pkg::IPL_W_RESP: begin
                if (s_axi_bready) begin
                    wstate_d = ipl_pkg::IPL_W_IDLE;
                end
            end
            default: begin
                wstate_d = ipl_pkg::IPL_W_IDLE;
            end
        endcase
    end

    // write state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_q <= ipl_pkg::IPL_W_IDLE;
        end else begin
            wstate_q <= wstate_d;
        end
    end

    // captured address and its response; unmapped words answer slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            widx_q  <= '0;
            bresp_q <= `IPL_RESP_OKAY;
        end else if (aw_hs) begin
            widx_q  <= word_idx(s_axi_awaddr);
            bresp_q <= ipl_pkg::is_mapped(word_idx(s_axi_awaddr)) ? `IPL_RESP_OKAY
                                                                   : `IPL_RESP_SLVERR;
        end
    end

    // captured data; registers are 16 bits, so upper lanes are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (w_hs) begin
            wdata_q <= s_axi_wdata[15:0];
            wstrb_q <= s_axi_wstrb[1:0];
        end
    end

    // priority registers; the mask keeps reserved bits at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio2_q <= `IPL_RESET_VAL;
        end else if (wr_fire && (widx_q == `IPL_IDX_PRIO2)) begin
            prio2_q <= merge(prio2_q, wdata_q, wstrb_q, `IPL_WMASK_PRIO2);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio3_q <= `IPL_RESET_VAL;
        end else if (wr_fire && (widx_q == `IPL_IDX_PRIO3)) begin
            prio3_q <= merge(prio3_q, wdata_q, wstrb_q, `IPL_WMASK_PRIO3);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio4_q <= `IPL_RESET_VAL;
        end else if (wr_fire && (widx_q == `IPL_IDX_PRIO4)) begin
            prio4_q <= merge(prio4_q, wdata_q, wstrb_q, `IPL_WMASK_PRIO4);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio5_q <= `IPL_RESET_VAL;
        end else if (wr_fire && (widx_q == `IPL_IDX_PRIO5)) begin
            prio5_q <= merge(prio5_q, wdata_q, wstrb_q, `IPL_WMASK_PRIO5);
        end
    end

    // read channel: one read in flight, data registered at the address edge
    assign s_axi_arready = !rvalid_q;
    assign ar_hs         = s_axi_arvalid && s_axi_arready;
    assign ridx          = word_idx(s_axi_araddr);
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // upper half of the word always reads zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= '0;
            rresp_q <= `IPL_RESP_OKAY;
        end else if (ar_hs) begin
            rdata_q <= {16'h0000, read_word(ridx, prio2_q, prio3_q, prio4_q, prio5_q)};
            rresp_q <= ipl_pkg::is_mapped(ridx) ? `IPL_RESP_OKAY : `IPL_RESP_SLVERR;
        end
    end

    // named fields of the second register
    assign pll_unlock_level      = prio2_q[`IPL_LSB_PLL_UNLOCK +: 2];
    assign low_voltage_level     = prio2_q[`IPL_LSB_LOW_VOLTAGE +: 2];
    assign ext_line_b_level      = prio2_q[`IPL_LSB_EXT_LINE_B +: 2];
    assign ext_line_a_level      = prio2_q[`IPL_LSB_EXT_LINE_A +: 2];

    // named fields of the third register
    assign port_d_level          = prio3_q[`IPL_LSB_PORT_D +: 2];
    assign port_e_level          = prio3_q[`IPL_LSB_PORT_E +: 2];
    assign port_f_level          = prio3_q[`IPL_LSB_PORT_F +: 2];
    assign can_msgbuf_level      = prio3_q[`IPL_LSB_CAN_MSGBUF +: 2];
    assign can_wakeup_level      = prio3_q[`IPL_LSB_CAN_WAKEUP +: 2];
    assign can_error_level       = prio3_q[`IPL_LSB_CAN_ERROR +: 2];
    assign can_busoff_level      = prio3_q[`IPL_LSB_CAN_BUSOFF +: 2];

    // named fields of the fourth register
    assign serial0_rxfull_level  = prio4_q[`IPL_LSB_SERIAL0_RXFULL +: 2];
    assign serial1_txempty_level = prio4_q[`IPL_LSB_SERIAL1_TXEMPTY +: 2];
    assign serial1_rxfull_level  = prio4_q[`IPL_LSB_SERIAL1_RXFULL +: 2];
    assign port_a_level          = prio4_q[`IPL_LSB_PORT_A +: 2];
    assign port_b_level          = prio4_q[`IPL_LSB_PORT_B +: 2];
    assign port_c_level          = prio4_q[`IPL_LSB_PORT_C +: 2];

    // named fields of the fifth register
    assign decoder1_index_level  = prio5_q[`IPL_LSB_DECODER1_INDEX +: 2];
    assign decoder1_home_level   = prio5_q[`IPL_LSB_DECODER1_HOME +: 2];
    assign uart1_rxfull_level    = prio5_q[`IPL_LSB_UART1_RXFULL +: 2];
    assign uart1_rxerror_level   = prio5_q[`IPL_LSB_UART1_RXERROR +: 2];
    assign uart1_txidle_level    = prio5_q[`IPL_LSB_UART1_TXIDLE +: 2];
    assign uart1_txempty_level   = prio5_q[`IPL_LSB_UART1_TXEMPTY +: 2];
    assign serial0_txempty_level = prio5_q[`IPL_LSB_SERIAL0_TXEMPTY +: 2];

    // source n sits at field pair n; order matches src_req bits
    assign fields = {serial0_txempty_level, uart1_txempty_level, uart1_txidle_level,
                     uart1_rxerror_level, uart1_rxfull_level, decoder1_home_level,
                     decoder1_index_level, port_c_level, port_b_level, port_a_level,
                     serial1_rxfull_level, serial1_txempty_level, serial0_rxfull_level,
                     can_busoff_level, can_error_level, can_wakeup_level,
                     can_msgbuf_level, port_f_level, port_e_level, port_d_level,
                     ext_line_a_level, ext_line_b_level, low_voltage_level,
                     pll_unlock_level};

    // gating by field code; disabled sources drop out here
    ipl_level_decode u_decode (
        .aclk    (aclk),
        .aresetn (aresetn),
        .fields  (fields),
        .src_req (src_req),
        .lvl     (core_lvl)
    );

    // highest pending level summary for the core's arbitration
    ipl_level_top u_top (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lvl     (core_lvl),
        .top     (core_top)
    );

endmodule : ipl_prio_regs

// ---- dv/ipl_prio_checker.sv ----
// assertions on the priority block bus answers and level outputs
`timescale 1ns/100ps
module ipl_prio_checker (
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         s_axi_awvalid,
    input wire logic         s_axi_awready,
    input wire logic         s_axi_wvalid,
    input wire logic         s_axi_wready,
    input wire logic         s_axi_bvalid,
    input wire logic [11:0]  s_axi_araddr,
    input wire logic         s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic [31:0]  s_axi_rdata,
    input wire logic         s_axi_rvalid,
    input wire logic [23:0]  src_req,
    input ipl_pkg::ipl_lvl_t core_lvl,
    input ipl_pkg::ipl_top_t core_top
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic        ar_hs;
    logic        aww_hs;
    logic [15:0] rsvd_q;
    // handshakes seen this edge
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign aww_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // reserved bits of the word being read
    always_ff @(posedge aclk) begin
        if (ar_hs) begin
            case (s_axi_araddr[11:2])
                10'h002: rsvd_q <= 16'hFC30;
                10'h003: rsvd_q <= 16'h0003;
                10'h004: rsvd_q <= 16'h03C0;
                10'h005: rsvd_q <= 16'h00C0;
                default: rsvd_q <= 16'hFFFF;
            endcase
        end
    end
    write_lat_a: assert property (aww_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer off time");
    read_lat_a: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer late");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    rsvd_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata[15:0] & rsvd_q) == 16'h0000)
        else $error("reserved bit read as one");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half set");
    lvl_gated_a: assert property (((core_lvl.lvl0 | core_lvl.lvl1 | core_lvl.lvl2)
        & ~$past(src_req)) == 24'h000000) else $error("request without source");
    one_level_a: assert property (((core_lvl.lvl0 & core_lvl.lvl1) |
        (core_lvl.lvl0 & core_lvl.lvl2) | (core_lvl.lvl1 & core_lvl.lvl2)) == 24'h000000)
        else $error("source at two levels");
    top_high_a: assert property (|core_lvl.lvl2 |=> core_top.any && core_top.level == 2'h2)
        else $error("summary missed level 2");
    top_idle_a: assert property (core_lvl == '0 |=> core_top == '0)
        else $error("summary without request");
    cover property (aww_hs);
    cover property (|core_lvl.lvl2);
    cover property (ar_hs && s_axi_araddr[11:2] == 10'h006);
endmodule : ipl_prio_checker

bind ipl_prio_regs ipl_prio_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .src_req, .core_lvl, .core_top);

// ---- dv/ipl_src_model.sv ----
// peripheral request sources feeding the priority block
`timescale 1ns/100ps
module ipl_src_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [23:0] want,
    input  wire logic        slow,
    output logic [23:0]      src_req
);
    logic [23:0] stage_q;
    // slow sources raise and drop a request one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_q <= 24'h000000;
            src_req <= 24'h000000;
        end else begin
            stage_q <= want;
            src_req <= slow ? stage_q : want;
        end
    end
endmodule : ipl_src_model

// ---- dv/tb_top.sv ----
// self-checking bench for the priority level registers
`timescale 1ns/100ps
`include "ipl_map.svh"
module tb_top;
    logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, slow;
    logic [11:0]       awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic [23:0]       want, src_req;
    ipl_pkg::ipl_lvl_t core_lvl;
    ipl_pkg::ipl_top_t core_top;
    int                error_cnt, comparisons;
    localparam logic [11:0] addr_t [4] = '{12'h008, 12'h00C, 12'h010, 12'h014};
    localparam logic [15:0] mask_t [4] = '{16'h03CF, 16'hFFFC, 16'hFC3F, 16'hFF3F};
    localparam int          lv_src [8] = '{0, 3, 4, 10, 11, 16, 17, 23};
    localparam int          lv_lsb [8] = '{8, 0, 14, 2, 14, 0, 14, 0};

    ipl_prio_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_req(src_req),
        .core_lvl(core_lvl), .core_top(core_top));
    ipl_src_model u_src (.aclk(aclk), .aresetn(aresetn), .want(want), .slow(slow),
        .src_req(src_req));

    // 10 MHz clock
    always #50 aclk = ~aclk;

    task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // write one word; address and data offered together, held until taken
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
                      input logic [1:0] resp);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {16'hA5A5, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check("bresp", resp, bresp);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic [1:0] resp);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        check("rdata", {16'h0000, exp}, rdata);
        check("rresp", resp, rresp);
    endtask : rd

    task automatic t_reset();
        check("core_lvl", 72'h0, core_lvl);
        for (int i = 0; i < 4; i++) rd(addr_t[i], 16'h0000, `IPL_RESP_OKAY);
        $display("test reset done");
    endtask : t_reset

    // all ones shows every field and reserved hole; byte lanes merge apart
    task automatic t_mask();
        for (int i = 0; i < 4; i++) begin
            wr(addr_t[i], 16'hFFFF, 4'hF, `IPL_RESP_OKAY);
            rd(addr_t[i], mask_t[i], `IPL_RESP_OKAY);
        end
        wr(addr_t[1], 16'h0000, 4'h1, `IPL_RESP_OKAY);
        rd(addr_t[1], 16'hFF00, `IPL_RESP_OKAY);
        wr(12'h018, 16'hFFFF, 4'hF, `IPL_RESP_SLVERR);
        rd(12'h018, 16'h0000, `IPL_RESP_SLVERR);
        rd(12'h004, 16'h0000, `IPL_RESP_SLVERR);
        for (int i = 0; i < 4; i++) wr(addr_t[i], 16'h0000, 4'hF, `IPL_RESP_OKAY);
        $display("test mask done");
    endtask : t_mask

    // every code of a field for eight sources, two per register, prompt and slow sources
    task automatic t_levels();
        logic [71:0] exp;
        for (int i = 0; i < 8; i++) begin
            for (int c = 0; c < 4; c++) begin
                wr(addr_t[i / 2], 16'(c) << lv_lsb[i], 4'h3, `IPL_RESP_OKAY);
                want <= 24'h1 << lv_src[i];
                slow <= c[0];
                repeat (6) @(posedge aclk);
                exp = (c == 0) ? 72'h0 : 72'h1 << (24 * (c - 1) + lv_src[i]);
                check("core_lvl", exp, core_lvl);
                exp = (c == 0) ? 72'h0 : {1'b1, 2'(c - 1), 5'(lv_src[i])};
                check("core_top", exp, core_top);
                want <= 24'h0;
                repeat (6) @(posedge aclk);
                check("core_lvl", 72'h0, core_lvl);
            end
        end
        $display("test levels done");
    endtask : t_levels

    // two sources: higher level wins, then lowest index at equal level
    task automatic t_arbit();
        wr(12'h008, 16'h0100, 4'h3, `IPL_RESP_OKAY);
        wr(12'h014, 16'h0003, 4'h3, `IPL_RESP_OKAY);
        want <= 24'h800001;
        repeat (6) @(posedge aclk);
        check("core_top", {1'b1, 2'h2, 5'h17}, core_top);
        wr(12'h014, 16'h0002, 4'h3, `IPL_RESP_OKAY);
        wr(12'h008, 16'h0200, 4'h3, `IPL_RESP_OKAY);
        repeat (6) @(posedge aclk);
        check("core_top", {1'b1, 2'h1, 5'h00}, core_top);
        want <= 24'h0;
        $display("test arbit done");
    endtask : t_arbit

    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // watchdog; tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 8'h00;
        {awaddr, araddr, wdata, wstrb, want} = 84'h0;
        error_cnt = 0;
        comparisons = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_mask();
        t_levels();
        t_arbit();
        summarize();
    end
endmodule : tb_top
